// File: design/port_route_consts.vh
// Constants for the port signal routing configuration block
// Summary of operation
// - Alternate bit moves clock/event pin 7 to 4
// - Slow timer clock route: off, C6, D6, R0
// - Rate pick: base, double, quadruple, reserved
// - Clock port pick: off, C, D, E
// - Peripheral clock defaults to pin 7
// - Clock beats event on same pin
// - Clock driven only when pin is output
// - Comparator port pick: A, C, D, R
// - Comparator enable lives in comparator, not here
// - Event port pick for channel: off, C, D, R
// - Event pin 7 on C/D, 0 on R
// - Event driven only when pin is output
// - Async enable bypasses event synchroniser
// - Three-bit channel pick selects one of eight
// - Slew bits: 7 R, 3 D, 2 C, 0 A
// - Reserved bits read zero, ignore writes
// - Virtual direction: one bit per pin, 1=output
// - Virtual direction aliases real direction register
// - Virtual output: one level bit per pin
// - Virtual output aliases real output register
// - Virtual input returns real input register
// - Virtual flags alias real; write one clears
`ifndef PORT_ROUTE_CONSTS_VH
`define PORT_ROUTE_CONSTS_VH

// Register indices; byte address is four times the index
`define IDX_VP_DIR 3'h0
`define IDX_VP_OUT 3'h1
`define IDX_VP_IN 3'h2
`define IDX_VP_FLAGS 3'h3
`define IDX_CLK_ROUTE 3'h4
`define IDX_ACEV_ROUTE 3'h6
`define IDX_SLEW 3'h7

// Writable bit masks and reset value
`define CLK_ROUTE_MASK 8'h_EF
`define SLEW_MASK 8'h_8D
`define CFG_RESET 8'h_00

// Clock routing field positions
`define ALT_PIN_BIT 7
`define RTC_ROUTE_HI 6
`define RTC_ROUTE_LO 5
`define RATE_HI 3
`define RATE_LO 2
`define CLK_PORT_HI 1
`define CLK_PORT_LO 0

// Comparator and event routing field positions
`define AC_PORT_HI 7
`define AC_PORT_LO 6
`define EV_PORT_HI 5
`define EV_PORT_LO 4
`define EV_ASYNC_BIT 3
`define EV_CH_HI 2
`define EV_CH_LO 0

// Slew limit bit positions
`define SLEW_R_BIT 7
`define SLEW_D_BIT 3
`define SLEW_C_BIT 2
`define SLEW_A_BIT 0

// Field codes
`define CODE_OFF 2'h0
`define CODE_C 2'h1
`define CODE_D 2'h2
`define CODE_3 2'h3
`define RATE_X1 2'h0
`define RATE_X2 2'h1
`define RATE_X4 2'h2

// Pin numbers
`define PIN_DEFAULT 3'h7
`define PIN_ALT 3'h4
`define PIN_RTC 3'h6
`define PIN_R 3'h0

`endif

// File: design/port_signal_routing_config.v
// Global port configuration registers and signal routing onto port pins
//
// Added by the designer: the Avalon-MM slave port.
`timescale 1ns/10ps
`include "port_route_consts.vh"

module port_signal_routing_config (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Avalon-MM slave, byte address
  input wire [4:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output wire avs_waitrequest,
  // Real registers of the port mapped onto the virtual window
  input wire [7:0] vp_dir_cur,
  input wire [7:0] vp_out_cur,
  input wire [7:0] vp_in_cur,
  input wire [7:0] vp_flags_cur,
  output reg vp_dir_wr,
  output reg vp_out_wr,
  output reg vp_in_wr,
  output reg vp_flags_clr,
  output reg [7:0] vp_wdata,
  // Sources to route
  input wire clk_per,
  input wire clk_per2,
  input wire clk_per4,
  input wire rtc_clk,
  input wire [7:0] ev_ch,
  // Direction registers of the destination ports
  input wire [7:0] dir_c,
  input wire [7:0] dir_d,
  input wire [7:0] dir_e,
  input wire [7:0] dir_r,
  // Pin overrides towards the port output stages
  output wire [7:0] ovr_en_c,
  output wire [7:0] ovr_val_c,
  output wire [7:0] ovr_en_d,
  output wire [7:0] ovr_val_d,
  output wire [7:0] ovr_en_e,
  output wire [7:0] ovr_val_e,
  output wire [7:0] ovr_en_r,
  output wire [7:0] ovr_val_r,
  // Comparator steering and slew limit enables
  output wire [1:0] comparator_port_pick,
  output wire slew_limit_port_a,
  output wire slew_limit_port_c,
  output wire slew_limit_port_d,
  output wire slew_limit_port_r
);

  reg [7:0] clk_route_r;
  reg [7:0] acev_route_r;
  reg [7:0] slew_r;
  reg ack_r;
  reg ev_sync_r;

  wire [2:0] idx;
  wire req;
  wire wr_go;
  wire [7:0] wbyte;

  wire routed_output_alt_pin;
  wire [1:0] slow_timer_clock_route;
  wire [1:0] peripheral_clock_rate_pick;
  wire [1:0] peripheral_clock_port_pick;
  wire [1:0] event_port_pick;
  wire async_event_route_enable;
  wire [2:0] event_channel_pick;

  reg clk_val;
  reg clk_ok;
  wire ev_raw;
  wire ev_val;
  wire [2:0] ce_pin;

  // Override for one port: clock first, then event, then slow timer clock
  function [15:0] route_port;
    input clk_hit;
    input ev_hit;
    input [2:0] ev_pin;
    input rtc_hit;
    input [2:0] rtc_pin;
    input [7:0] dir;
    input cv;
    input evv;
    input rv;
    integer i;
    reg [7:0] en;
    reg [7:0] val;
    begin
      en = 8'h_00;
      val = 8'h_00;
      for (i = 0; i < 8; i = i + 1) begin
        if (clk_hit && (ce_pin == i) && dir[i]) begin
          en[i] = 1'b1;
          val[i] = cv;
        end else if (ev_hit && (ev_pin == i) && dir[i]) begin
          en[i] = 1'b1;
          val[i] = evv;
        end else if (rtc_hit && (rtc_pin == i)) begin
          en[i] = 1'b1;
          val[i] = rv;
        end
      end
      route_port = {en, val};
    end
  endfunction

  // Bus access: one wait cycle, then the answer
  assign idx = avs_address[4:2];
  assign req = avs_read | avs_write;
  assign avs_waitrequest = req & ~ack_r;
  assign wr_go = avs_write & ack_r & avs_byteenable[0];
  assign wbyte = avs_writedata[7:0];

  always @(posedge clk) begin
    if (rst) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= req & ~ack_r;
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      clk_route_r <= `CFG_RESET;
      acev_route_r <= `CFG_RESET;
      slew_r <= `CFG_RESET;
    end else if (wr_go) begin
      case (idx)
        `IDX_CLK_ROUTE: begin
          clk_route_r <= wbyte & `CLK_ROUTE_MASK;
        end
        `IDX_ACEV_ROUTE: begin
          acev_route_r <= wbyte;
        end
        `IDX_SLEW: begin
          slew_r <= wbyte & `SLEW_MASK;
        end
        default: begin
        end
      endcase
    end
  end

  // Virtual window keeps no copy; accesses pass to the mapped port
  always @(posedge clk) begin
    if (rst) begin
      vp_dir_wr <= 1'b0;
      vp_out_wr <= 1'b0;
      vp_in_wr <= 1'b0;
      vp_flags_clr <= 1'b0;
      vp_wdata <= 8'h_00;
    end else begin
      vp_dir_wr <= wr_go && (idx == `IDX_VP_DIR);
      vp_out_wr <= wr_go && (idx == `IDX_VP_OUT);
      vp_in_wr <= wr_go && (idx == `IDX_VP_IN);
      vp_flags_clr <= wr_go && (idx == `IDX_VP_FLAGS);
      if (wr_go) begin
        vp_wdata <= wbyte;
      end
    end
  end

  // Read data captured in the wait cycle and held through the answer
  always @(posedge clk) begin
    if (rst) begin
      avs_readdata <= 32'h_0000_0000;
    end else if (avs_read && !ack_r) begin
      case (idx)
        `IDX_VP_DIR: avs_readdata <= {24'h_00_0000, vp_dir_cur};
        `IDX_VP_OUT: avs_readdata <= {24'h_00_0000, vp_out_cur};
        `IDX_VP_IN: avs_readdata <= {24'h_00_0000, vp_in_cur};
        `IDX_VP_FLAGS: avs_readdata <= {24'h_00_0000, vp_flags_cur};
        `IDX_CLK_ROUTE: avs_readdata <= {24'h_00_0000, clk_route_r};
        `IDX_ACEV_ROUTE: avs_readdata <= {24'h_00_0000, acev_route_r};
        `IDX_SLEW: avs_readdata <= {24'h_00_0000, slew_r};
        default: avs_readdata <= 32'h_0000_0000;
      endcase
    end
  end

  // Field views
  assign routed_output_alt_pin = clk_route_r[`ALT_PIN_BIT];
  assign slow_timer_clock_route = clk_route_r[`RTC_ROUTE_HI:`RTC_ROUTE_LO];
  assign peripheral_clock_rate_pick = clk_route_r[`RATE_HI:`RATE_LO];
  assign peripheral_clock_port_pick = clk_route_r[`CLK_PORT_HI:`CLK_PORT_LO];
  assign event_port_pick = acev_route_r[`EV_PORT_HI:`EV_PORT_LO];
  assign async_event_route_enable = acev_route_r[`EV_ASYNC_BIT];
  assign event_channel_pick = acev_route_r[`EV_CH_HI:`EV_CH_LO];

  // Comparator enable stays in the comparator; only the port is steered
  assign comparator_port_pick = acev_route_r[`AC_PORT_HI:`AC_PORT_LO];

  assign slew_limit_port_a = slew_r[`SLEW_A_BIT];
  assign slew_limit_port_c = slew_r[`SLEW_C_BIT];
  assign slew_limit_port_d = slew_r[`SLEW_D_BIT];
  assign slew_limit_port_r = slew_r[`SLEW_R_BIT];

  assign ce_pin = routed_output_alt_pin ? `PIN_ALT : `PIN_DEFAULT;

  // Clock rate selection; reserved code leaves the pin to the port
  always @* begin
    clk_ok = 1'b1;
    case (peripheral_clock_rate_pick)
      `RATE_X1: clk_val = clk_per;
      `RATE_X2: clk_val = clk_per2;
      `RATE_X4: clk_val = clk_per4;
      default: begin
        clk_val = 1'b0;
        clk_ok = 1'b0;
      end
    endcase
  end

  // Synchronous path costs one cycle; async path is a pure mux
  assign ev_raw = ev_ch[event_channel_pick];

  always @(posedge clk) begin
    if (rst) begin
      ev_sync_r <= 1'b0;
    end else begin
      ev_sync_r <= ev_raw;
    end
  end

  assign ev_val = async_event_route_enable ? ev_raw : ev_sync_r;

  // Port C: clock code 01, event code 01, slow timer code 01 on pin 6
  assign {ovr_en_c, ovr_val_c} = route_port(
    clk_ok && (peripheral_clock_port_pick == `CODE_C),
    event_port_pick == `CODE_C, ce_pin,
    slow_timer_clock_route == `CODE_C, `PIN_RTC,
    dir_c, clk_val, ev_val, rtc_clk);

  // Port D: code 10 for all three; slow timer 10 stays on D
  assign {ovr_en_d, ovr_val_d} = route_port(
    clk_ok && (peripheral_clock_port_pick == `CODE_D),
    event_port_pick == `CODE_D, ce_pin,
    slow_timer_clock_route == `CODE_D, `PIN_RTC,
    dir_d, clk_val, ev_val, rtc_clk);

  // Port E: only the peripheral clock reaches it
  assign {ovr_en_e, ovr_val_e} = route_port(
    clk_ok && (peripheral_clock_port_pick == `CODE_3),
    1'b0, ce_pin,
    1'b0, `PIN_RTC,
    dir_e, clk_val, ev_val, rtc_clk);

  // Port R: event and slow timer clock both on pin 0
  assign {ovr_en_r, ovr_val_r} = route_port(
    1'b0,
    event_port_pick == `CODE_3, `PIN_R,
    slow_timer_clock_route == `CODE_3, `PIN_R,
    dir_r, clk_val, ev_val, rtc_clk);

endmodule // port_signal_routing_config

// File: verification/port_route_checker_properties.sv
// Bus, alias and routing assertions for the port routing configuration block
`timescale 1ns/10ps
module port_route_checker (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Register bus
  input wire [4:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  input wire [31:0] avs_readdata,
  input wire avs_waitrequest,
  // Virtual window
  input wire [7:0] vp_dir_cur,
  input wire [7:0] vp_in_cur,
  input wire vp_dir_wr,
  input wire vp_out_wr,
  input wire vp_in_wr,
  input wire vp_flags_clr,
  input wire [7:0] vp_wdata,
  // Routing results
  input wire [7:0] ovr_en_c,
  input wire [1:0] comparator_port_pick,
  input wire slew_limit_port_a,
  input wire slew_limit_port_r
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire [2:0] idx = avs_address[4:2];
  wire wr_done = avs_write & ~avs_waitrequest & avs_byteenable[0];
  wire rd_take = avs_read & avs_waitrequest;
  property p_reset_clear;
    $fell(rst) |-> ovr_en_c == 8'h00 && comparator_port_pick == 2'h0 && !slew_limit_port_a;
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("state not clear after reset");
  property p_dir_write;
    wr_done && idx == 3'h0 |=> vp_dir_wr && vp_wdata == $past(avs_writedata[7:0]);
  endproperty
  a_dir_write: assert property (p_dir_write) else $error("direction write not passed on");
  property p_flag_clear;
    wr_done && idx == 3'h3 |=> vp_flags_clr ##1 !vp_flags_clr;
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("flag clear strobe wrong");
  property p_dir_read;
    rd_take && idx == 3'h0 |=> avs_readdata == {24'h00_0000, $past(vp_dir_cur)};
  endproperty
  a_dir_read: assert property (p_dir_read) else $error("direction read wrong");
  property p_in_read;
    rd_take && idx == 3'h2 |=> avs_readdata[7:0] == $past(vp_in_cur);
  endproperty
  a_in_read: assert property (p_in_read) else $error("input read wrong");
  property p_slew_rsvd;
    rd_take && idx == 3'h7 |=> avs_readdata[6:4] == 3'h0 && !avs_readdata[1];
  endproperty
  a_slew_rsvd: assert property (p_slew_rsvd) else $error("reserved slew bits not zero");
  property p_slew_follow;
    wr_done && idx == 3'h7 |=> slew_limit_port_r == $past(avs_writedata[7]) && slew_limit_port_a == $past(avs_writedata[0]);
  endproperty
  a_slew_follow: assert property (p_slew_follow) else $error("slew enable not updated");
  property p_cmp_pick;
    wr_done && idx == 3'h6 |=> comparator_port_pick == $past(avs_writedata[7:6]);
  endproperty
  a_cmp_pick: assert property (p_cmp_pick) else $error("comparator pick not updated");
  property p_out_write;
    wr_done && idx == 3'h1 |=> vp_out_wr && !vp_dir_wr && vp_wdata == $past(avs_writedata[7:0]);
  endproperty
  a_out_write: assert property (p_out_write) else $error("output write not passed on");
  property p_in_write;
    wr_done && idx == 3'h2 |=> vp_in_wr && !vp_out_wr ##1 !vp_in_wr;
  endproperty
  a_in_write: assert property (p_in_write) else $error("input write strobe wrong");
endmodule // port_route_checker

// File: verification/test_port_signal_routing_config.sv
// Self-checking bench for the port routing configuration block
`timescale 1ns/10ps
module test_port_signal_routing_config;
  logic clk = 0, rst = 1, avs_read = 0, avs_write = 0, clk_per = 0, clk_per2 = 0, clk_per4 = 0, rtc_clk = 1;
  logic [4:0] avs_address = 0;
  logic [31:0] avs_writedata = 0;
  logic [3:0] avs_byteenable = 4'h1;
  logic [7:0] vp_dir_cur = 8'hA5, vp_out_cur = 8'h5A, vp_in_cur = 8'hC3, vp_flags_cur = 8'h3C, ev_ch = 0, dir = 8'hFF;
  wire [31:0] avs_readdata;
  wire [7:0] vp_wdata, ovr_en_c, ovr_val_c, ovr_en_d, ovr_val_d, ovr_en_e, ovr_val_e, ovr_en_r, ovr_val_r;
  wire [1:0] comparator_port_pick;
  wire avs_waitrequest, vp_dir_wr, vp_out_wr, vp_in_wr, vp_flags_clr;
  wire slew_limit_port_a, slew_limit_port_c, slew_limit_port_d, slew_limit_port_r;
  wire [31:0] en_all = {ovr_en_r, ovr_en_e, ovr_en_d, ovr_en_c};
  wire [31:0] shown = en_all & {ovr_val_r, ovr_val_e, ovr_val_d, ovr_val_c};
  int n_fail = 0, compares = 0;
  port_signal_routing_config i_dut (.clk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .vp_dir_cur, .vp_out_cur, .vp_in_cur, .vp_flags_cur,
    .vp_dir_wr, .vp_out_wr, .vp_in_wr, .vp_flags_clr, .vp_wdata, .clk_per, .clk_per2, .clk_per4, .rtc_clk,
    .ev_ch, .dir_c(dir), .dir_d(dir), .dir_e(dir), .dir_r(dir), .ovr_en_c, .ovr_val_c, .ovr_en_d, .ovr_val_d,
    .ovr_en_e, .ovr_val_e, .ovr_en_r, .ovr_val_r, .comparator_port_pick, .slew_limit_port_a,
    .slew_limit_port_c, .slew_limit_port_d, .slew_limit_port_r);
  initial forever #2 clk = ~clk;
  task automatic conclude;
    if (n_fail == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // Request held until waitrequest is seen low at an edge
  task automatic acc(input logic w, input logic [2:0] i, input logic [7:0] d, output logic [31:0] q);
    int n;
    avs_address <= {i, 2'b00};
    avs_writedata <= {24'h00_0000, d};
    avs_write <= w;
    avs_read <= !w;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest && n < 16);
    if (n >= 16) n_fail++;
    q = avs_readdata;
    avs_write <= 0;
    avs_read <= 0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [2:0] i, input logic [7:0] d);
    logic [31:0] q;
    acc(1, i, d, q);
  endtask
  task automatic rc(input logic [2:0] i, input logic [31:0] e);
    logic [31:0] q;
    acc(0, i, 8'h00, q);
    chk(q, e);
  endtask
  initial begin
    repeat (4) @(posedge clk);
    rst <= 0;
    rc(4, 0);
    rc(6, 0);
    rc(7, 0);
    rc(0, 8'hA5);
    rc(1, 8'h5A);
    rc(2, 8'hC3);
    rc(3, 8'h3C);
    wr(0, 8'h96);
    chk(vp_wdata, 8'h96);
    wr(1, 8'h3C);
    chk(vp_wdata, 8'h3C);
    wr(2, 8'h81);
    chk(vp_wdata, 8'h81);
    wr(3, 8'h0F);
    wr(7, 8'hFF);
    rc(7, 8'h8D);
    chk({slew_limit_port_r, slew_limit_port_d, slew_limit_port_c, slew_limit_port_a}, 4'hF);
    wr(4, 8'hFF);
    rc(4, 8'hEF);
    chk(en_all, 32'h0100_0000);
    wr(5, 8'hFF);
    rc(5, 0);
    for (int k = 0; k < 4; k++) begin
      wr(6, 8'(k << 6));
      chk(comparator_port_pick, k);
    end
    for (int p = 1; p < 4; p++) for (int r = 0; r < 3; r++) begin
      wr(4, 8'((r << 2) | p));
      chk(en_all, 32'h80 << 8 * (p - 1));
      for (int s = 0; s < 3; s++) begin
        {clk_per4, clk_per2, clk_per} <= 3'(1 << s);
        @(posedge clk);
        chk(shown, (r == s ? 32'h80 : 0) << 8 * (p - 1));
      end
    end
    dir <= 0;
    @(posedge clk);
    chk(en_all, 0);
    dir <= 8'hFF;
    wr(4, 8'h81);
    chk(en_all, 32'h10);
    wr(4, 8'h01);
    wr(6, 8'h18);
    {clk_per4, clk_per2, clk_per} <= 3'b000;
    ev_ch <= 8'h01;
    @(posedge clk);
    chk(en_all, 32'h80);
    chk(shown[7:0], 8'h00);
    clk_per <= 1'b1;
    ev_ch <= 8'h00;
    @(posedge clk);
    chk(shown[7:0], 8'h80);
    wr(4, 8'h00);
    for (int p = 1; p < 4; p++) for (int c = 0; c < 8; c++) begin
      wr(6, 8'((p << 4) | 8 | c));
      chk(en_all, p == 3 ? 32'h0100_0000 : 32'h80 << 8 * (p - 1));
      ev_ch <= 8'h01 << c;
      #1 chk(shown, en_all);
      @(posedge clk) ev_ch <= ~(8'h01 << c);
      #1 chk(shown, 0);
    end
    wr(6, 8'h10);
    ev_ch <= 0;
    @(posedge clk) ev_ch <= 8'h01;
    #1 chk(shown, 0);
    @(posedge clk);
    #1 chk(shown, 32'h80);
    dir <= 0;
    #1 chk(en_all, 0);
    @(posedge clk);
    for (int r = 1; r < 4; r++) begin
      wr(4, 8'(r << 5));
      chk(en_all, r == 1 ? 32'h40 : r == 2 ? 32'h4000 : 32'h0100_0000);
    end
    rst <= 1;
    @(posedge clk);
    rst <= 0;
    rc(4, 0);
    chk(en_all, 0);
    conclude();
  end
  initial begin
    #40000;
    n_fail++;
    conclude();
  end
endmodule // test_port_signal_routing_config
bind port_signal_routing_config port_route_checker u_chk (.clk, .rst, .avs_address, .avs_read, .avs_write,
  .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .vp_dir_cur, .vp_in_cur, .vp_dir_wr,
  .vp_out_wr, .vp_in_wr,
  .vp_flags_clr, .vp_wdata, .ovr_en_c, .comparator_port_pick, .slew_limit_port_a, .slew_limit_port_r);
